// ### rtl/ems_pkg.sv
// Purpose: Shared constants and types for the external memory cycle sequencer.
// Assumes: One sequencer tick per half clock period; ref_clk at 100 MHz.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
package ems_pkg;

  // Clock and half-period timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_PERIOD_NS = 10;
  // Sequencer ticks per half period (one by construction)
  localparam int HALF_PERIOD_CYC = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_TIMING = 5'h14;
  localparam logic [4:0] REG_STROBE = 5'h18;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_INT_BIT = 2;
  localparam int CTRL_BE_LSB = 4;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAITED_BIT = 1;

  // Timing register: T1..T5 two bits each (length minus one), T6 three bits
  localparam int TIM_W = 13;
  localparam int TIM_FLD_W = 2;
  localparam int TIM_T6_LSB = 10;
  localparam logic [2:0] T6_LAST_MAX = 3'h4;
  localparam logic [12:0] TIM_RST = 13'h0fff;

  // Strobe register: duration, three delays, write mode
  localparam int STR_W = 21;
  localparam int STR_FLD_W = 5;
  localparam int STR_DUR_LSB = 0;
  localparam int STR_DLY_LSB = 5;
  localparam int STR_EARLY_BIT = 20;
  localparam logic [20:0] STR_RST = 21'h00_0000;

  // Strobe-relative counter saturates above the largest setting
  localparam logic [5:0] SCNT_MAX = 6'h3f;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_WAIT, ST_T5, ST_T6, ST_PAD
  } ems_state_t;

endpackage

// ### rtl/ems_seq.sv
// Purpose: External memory cycle sequencer with Avalon-MM register access.
// Assumes: One ref_clk cycle per half clock period; pins sampled at ref_clk.
// Notes: Wait input is filtered by three flops; data is sampled at end of T5.
// What this block does
// - Read strobe low in T4 and T5
// - Read data sampled at T5 end, bus released
// - Reads always fetch the whole word
// - Fixed strobe low from T2 to T5 end
// - Duration strobe low configured count from T2
// - Wait states do not stretch duration strobe
// - Zero duration keeps duration strobe high
// - Delayed strobes fall after delay, rise T5
// - Zero delay: low T1-T5, high first T6
// - Cycle T1..T6 plus wait, configured lengths, T6 at most five
// - Unwritten byte lanes tristated during write
// - Write flag low T1-T2, data T3-T6
// - Late write T4-T5, early adds T3
// - No write strobes on internal accesses
// - Wait request extends T4, sampled at falls
// - Wait acts externally, ignored for internal access
// - After waits, T5 starts on rising edge
// - No refresh logic; refresh flag driven high with address
// - Timing unit is one half clock period
// - Cycles even length, padded after T6
// - Address T1-T2, then 32 data bits
// - States T1-T6 four half-periods after reset
`timescale 1ns/1ps

module ems_seq (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic processor_clock_output,
  output logic read_strobe_n,
  output logic fixed_select_strobe_n,
  output logic duration_strobe_n,
  output logic delayed_strobe_a_n,
  output logic delayed_strobe_b_n,
  output logic delayed_strobe_c_n,
  output logic [3:0] byte_write_strobes_n,
  output logic write_flag_data_bit0_out,
  input wire logic write_flag_data_bit0_in,
  output logic write_flag_data_bit0_oe_n,
  output logic refresh_flag_data_bit1_out,
  input wire logic refresh_flag_data_bit1_in,
  output logic refresh_flag_data_bit1_oe_n,
  output logic [29:0] shared_addr_data_bus_out,
  input wire logic [29:0] shared_addr_data_bus_in,
  output logic [3:0] shared_addr_data_bus_oe_n,
  input wire logic wait_request
);

  // Whole module state
  typedef struct packed {
    ems_pkg::ems_state_t st;      // Sequencer state
    logic [2:0] cnt;              // Half periods spent in state
    logic [5:0] scnt;             // Half periods since T2 start
    logic pco;                    // Clock output level
    logic [2:0] wsync;            // Wait input filter chain
    logic wlev;                   // Filtered wait level
    logic wait_hold;              // Wait sampled at falling edge
    logic waited;                 // Wait states seen this cycle
    logic pend;                   // Cycle requested, not started
    logic is_wr;                  // Current cycle is a write
    logic is_int;                 // Current cycle is internal
    logic [3:0] be;               // Bytes to write
    logic [29:0] addr;            // Word address
    logic [31:0] wdata;           // Write word
    logic [31:0] rdata;           // Last read word
    logic [12:0] tim;             // State lengths
    logic [20:0] strc;            // Strobe setup and write mode
    logic avs_wait;               // Bus waitrequest
    logic [31:0] avs_rd;          // Bus read data
    logic rd_n;                   // Read strobe
    logic [4:0] s_n;              // General strobes 0..4
    logic [3:0] wr_n;             // Byte write strobes
    logic d0_out;                 // Bit 0 / write flag
    logic d0_oe_n;
    logic d1_out;                 // Bit 1 / refresh flag
    logic d1_oe_n;
    logic [29:0] bus_out;         // Shared bus drive value
    logic [3:0] bus_oe_n;         // Per byte lane enables
  } ems_regs_t;

  ems_regs_t r;
  ems_regs_t n;
  logic busy;                     // Cycle pending or running
  logic [2:0] last;               // Final half-period index of state
  logic [4:0] dly;                // Delay for one delayed strobe
  logic [31:0] mrg_addr, mrg_tim, mrg_str; // Register words after byte merge

  // Final count of a timing state from its field
  function automatic logic [2:0] state_last(input ems_pkg::ems_state_t s, input logic [12:0] t);
    logic [2:0] v;
    v = 3'h0;
    unique case (s)
      ems_pkg::ST_T1: v = {1'b0, t[0 +: ems_pkg::TIM_FLD_W]};
      ems_pkg::ST_T2: v = {1'b0, t[2 +: ems_pkg::TIM_FLD_W]};
      ems_pkg::ST_T3: v = {1'b0, t[4 +: ems_pkg::TIM_FLD_W]};
      ems_pkg::ST_T4: v = {1'b0, t[6 +: ems_pkg::TIM_FLD_W]};
      ems_pkg::ST_T5: v = {1'b0, t[8 +: ems_pkg::TIM_FLD_W]};
      ems_pkg::ST_T6: v = (t[ems_pkg::TIM_T6_LSB +: 3] > ems_pkg::T6_LAST_MAX) ?
                          ems_pkg::T6_LAST_MAX : t[ems_pkg::TIM_T6_LSB +: 3];
      ems_pkg::ST_IDLE, ems_pkg::ST_WAIT, ems_pkg::ST_PAD: v = 3'h0;
    endcase
    return v;
  endfunction

  // Byte-enable merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction

  assign busy = r.pend | (r.st != ems_pkg::ST_IDLE);
  assign last = state_last(r.st, r.tim);
  assign mrg_addr = merge({r.addr, 2'b00}, avs_writedata, avs_byteenable);
  assign mrg_tim = merge({19'h0_0000, r.tim}, avs_writedata, avs_byteenable);
  assign mrg_str = merge({11'h000, r.strc}, avs_writedata, avs_byteenable);

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    dly = 5'h00;
    // Clock output toggles every half period
    n.pco = ~r.pco;
    // Wait pin: three flops, level counts once stages two and three agree
    n.wsync = {r.wsync[1:0], wait_request};
    if (r.wsync[1] == r.wsync[2]) begin
      n.wlev = r.wsync[2];
    end

    // Bus slave: one-cycle waitrequest drop answers a request
    n.avs_wait = 1'b1;
    if ((avs_read || avs_write) && r.avs_wait) begin
      // Writes stall while a cycle runs so settings stay put
      if (!(avs_write && busy)) begin
        n.avs_wait = 1'b0;
        n.avs_rd = 32'h0000_0000;
        unique case (avs_address)
          ems_pkg::REG_ADDR: n.avs_rd = {r.addr, 2'b00};
          ems_pkg::REG_WDATA: n.avs_rd = r.wdata;
          ems_pkg::REG_RDATA: n.avs_rd = r.rdata;
          ems_pkg::REG_STATUS: begin
            n.avs_rd[ems_pkg::STAT_BUSY_BIT] = busy;
            n.avs_rd[ems_pkg::STAT_WAITED_BIT] = r.waited;
          end
          ems_pkg::REG_TIMING: n.avs_rd[ems_pkg::TIM_W-1:0] = r.tim;
          ems_pkg::REG_STROBE: n.avs_rd[ems_pkg::STR_W-1:0] = r.strc;
          default: n.avs_rd = 32'h0000_0000;
        endcase
      end
    end
    // Write takes effect at the edge where waitrequest is low
    if (avs_write && !r.avs_wait) begin
      unique case (avs_address)
        ems_pkg::REG_CTRL: begin
          if (avs_byteenable[0] && avs_writedata[ems_pkg::CTRL_START_BIT]) begin
            n.pend = 1'b1;
            n.is_wr = avs_writedata[ems_pkg::CTRL_WRITE_BIT];
            n.is_int = avs_writedata[ems_pkg::CTRL_INT_BIT];
            n.be = avs_writedata[ems_pkg::CTRL_BE_LSB +: 4];
          end
        end
        ems_pkg::REG_ADDR: n.addr = mrg_addr[31:2];
        ems_pkg::REG_WDATA: n.wdata = merge(r.wdata, avs_writedata, avs_byteenable);
        ems_pkg::REG_TIMING: n.tim = mrg_tim[12:0];
        ems_pkg::REG_STROBE: n.strc = mrg_str[20:0];
        default: n.pend = r.pend;
      endcase
    end

    // Wait sampled as the clock output falls, in T3, T4 or wait, not at T4 end
    if (r.pco && !r.is_int && (r.st == ems_pkg::ST_T3 || r.st == ems_pkg::ST_WAIT ||
        (r.st == ems_pkg::ST_T4 && r.cnt != last))) begin
      n.wait_hold = r.wlev;
    end else if (r.st != ems_pkg::ST_T4 && r.st != ems_pkg::ST_WAIT && r.st != ems_pkg::ST_T3) begin
      n.wait_hold = 1'b0;
    end

    // Sequencer: T1..T6 with wait and padding
    unique case (r.st)
      ems_pkg::ST_IDLE: begin
        // Start only where the next half period is high
        if (r.pend && !r.pco) begin
          n.st = ems_pkg::ST_T1;
          n.cnt = 3'h0;
          n.pend = 1'b0;
          n.waited = 1'b0;
        end
      end
      ems_pkg::ST_WAIT: begin
        // Leave wait only toward a rising edge, adding one half period if needed
        if (!r.wait_hold && !r.pco) begin
          n.st = ems_pkg::ST_T5;
          n.cnt = 3'h0;
        end
      end
      ems_pkg::ST_PAD: n.st = ems_pkg::ST_IDLE;
      ems_pkg::ST_T1, ems_pkg::ST_T2, ems_pkg::ST_T3, ems_pkg::ST_T4, ems_pkg::ST_T5, ems_pkg::ST_T6: begin
        // Each state lasts its configured count of half periods, T6 at most five
        if (r.cnt != last) begin
          n.cnt = r.cnt + 3'h1;
        end else begin
          n.cnt = 3'h0;
          unique case (r.st)
            ems_pkg::ST_T1: n.st = ems_pkg::ST_T2;
            ems_pkg::ST_T2: n.st = ems_pkg::ST_T3;
            ems_pkg::ST_T3: n.st = ems_pkg::ST_T4;
            ems_pkg::ST_T4: begin
              // Held wait request extends T4
              if (r.wait_hold) begin
                n.st = ems_pkg::ST_WAIT;
                n.waited = 1'b1;
              end else begin
                n.st = ems_pkg::ST_T5;
              end
            end
            ems_pkg::ST_T5: begin
              n.st = ems_pkg::ST_T6;
              // Whole word taken at end of T5
              if (!r.is_wr) begin
                n.rdata = {shared_addr_data_bus_in, refresh_flag_data_bit1_in, write_flag_data_bit0_in};
              end
            end
            default: n.st = r.pco ? ems_pkg::ST_PAD : ems_pkg::ST_IDLE;
          endcase
        end
      end
    endcase

    // Half-period count from T2 start, unaffected by state boundaries
    if (n.st == ems_pkg::ST_T2 && r.st == ems_pkg::ST_T1) begin
      n.scnt = 6'h00;
    end else if (r.scnt != ems_pkg::SCNT_MAX) begin
      n.scnt = r.scnt + 6'h01;
    end

    // Strobes, computed for the coming half period
    n.rd_n = 1'b1;
    n.s_n = 5'h1f;
    n.wr_n = 4'hf;
    if (!n.is_int) begin
      // Read strobe through T4, wait and T5
      if (!n.is_wr && (n.st == ems_pkg::ST_T4 || n.st == ems_pkg::ST_WAIT || n.st == ems_pkg::ST_T5)) begin
        n.rd_n = 1'b0;
      end
      // Fixed strobe from T2 start to T5 end
      if (n.st inside {ems_pkg::ST_T2, ems_pkg::ST_T3, ems_pkg::ST_T4, ems_pkg::ST_WAIT, ems_pkg::ST_T5}) begin
        n.s_n[0] = 1'b0;
      end
      // Duration strobe counts from T2, cut off after T6, never under zero setting
      if (n.st inside {ems_pkg::ST_T2, ems_pkg::ST_T3, ems_pkg::ST_T4, ems_pkg::ST_WAIT,
          ems_pkg::ST_T5, ems_pkg::ST_T6} &&
          n.scnt < {1'b0, n.strc[ems_pkg::STR_DUR_LSB +: ems_pkg::STR_FLD_W]}) begin
        n.s_n[1] = 1'b0;
      end
      // Delayed strobes two to four
      for (int i = 0; i < 3; i++) begin
        dly = n.strc[ems_pkg::STR_DLY_LSB + ems_pkg::STR_FLD_W*i +: ems_pkg::STR_FLD_W];
        if (dly == 5'h00) begin
          // Zero delay: low T1..T5, high only in first half period of T6
          if (n.st inside {ems_pkg::ST_T1, ems_pkg::ST_T2, ems_pkg::ST_T3, ems_pkg::ST_T4,
              ems_pkg::ST_WAIT, ems_pkg::ST_T5} || (n.st == ems_pkg::ST_T6 && n.cnt != 3'h0)) begin
            n.s_n[2+i] = 1'b0;
          end
        end else if (n.st inside {ems_pkg::ST_T2, ems_pkg::ST_T3, ems_pkg::ST_T4, ems_pkg::ST_WAIT,
            ems_pkg::ST_T5} && n.scnt >= {1'b0, dly}) begin
          n.s_n[2+i] = 1'b0;
        end
      end
      // Byte write strobes, early mode adds T3
      if (n.is_wr && (n.st == ems_pkg::ST_T4 || n.st == ems_pkg::ST_WAIT || n.st == ems_pkg::ST_T5 ||
          (n.st == ems_pkg::ST_T3 && n.strc[ems_pkg::STR_EARLY_BIT]))) begin
        n.wr_n = ~n.be;
      end
    end

    // Shared bus: address first, then data by lane
    n.bus_oe_n = 4'hf;
    n.d0_oe_n = 1'b1;
    n.d1_oe_n = 1'b1;
    n.bus_out = 30'h0000_0000;
    n.d0_out = 1'b1;
    n.d1_out = 1'b1;
    if (n.st != ems_pkg::ST_IDLE && (n.is_int || n.st == ems_pkg::ST_T1 || n.st == ems_pkg::ST_T2)) begin
      // Address and flags; internal cycles only reflect the address
      n.bus_out = n.addr;
      n.bus_oe_n = 4'h0;
      n.d0_out = ~n.is_wr;
      n.d0_oe_n = 1'b0;
      n.d1_out = 1'b1;
      n.d1_oe_n = 1'b0;
    end else if (n.st != ems_pkg::ST_IDLE && n.is_wr) begin
      // Write data from T3 through T6 and padding, only written lanes driven
      n.bus_out = n.wdata[31:2];
      n.d0_out = n.wdata[0];
      n.d1_out = n.wdata[1];
      n.bus_oe_n = ~n.be;
      n.d0_oe_n = ~n.be[0];
      n.d1_oe_n = ~n.be[0];
    end

    // Synchronous reset: four half periods per timing state, all strobes idle
    if (rst) begin
      n = '0;
      n.st = ems_pkg::ST_IDLE;
      n.tim = ems_pkg::TIM_RST;
      n.strc = ems_pkg::STR_RST;
      n.avs_wait = 1'b1;
      n.rd_n = 1'b1;
      n.s_n = 5'h1f;
      n.wr_n = 4'hf;
      n.d0_oe_n = 1'b1;
      n.d1_oe_n = 1'b1;
      n.bus_oe_n = 4'hf;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    r <= n;
  end

  // Outputs straight from state flops
  assign avs_readdata = r.avs_rd;
  assign avs_waitrequest = r.avs_wait;
  assign processor_clock_output = r.pco;
  assign read_strobe_n = r.rd_n;
  assign fixed_select_strobe_n = r.s_n[0];
  assign duration_strobe_n = r.s_n[1];
  assign delayed_strobe_a_n = r.s_n[2];
  assign delayed_strobe_b_n = r.s_n[3];
  assign delayed_strobe_c_n = r.s_n[4];
  assign byte_write_strobes_n = r.wr_n;
  assign write_flag_data_bit0_out = r.d0_out;
  assign write_flag_data_bit0_oe_n = r.d0_oe_n;
  assign refresh_flag_data_bit1_out = r.d1_out;
  assign refresh_flag_data_bit1_oe_n = r.d1_oe_n;
  assign shared_addr_data_bus_out = r.bus_out;
  assign shared_addr_data_bus_oe_n = r.bus_oe_n;

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Cycle entry and wait exit
  sequence seq_enter_t1;
    r.st == ems_pkg::ST_IDLE ##1 r.st == ems_pkg::ST_T1;
  endsequence
  sequence seq_wait_to_t5;
    r.st == ems_pkg::ST_WAIT ##1 r.st == ems_pkg::ST_T5;
  endsequence

  chk_read_strobe_win: assert property (!read_strobe_n |-> !r.is_wr && !r.is_int &&
      r.st inside {ems_pkg::ST_T4, ems_pkg::ST_WAIT, ems_pkg::ST_T5})
    else $error("read strobe low outside T4/T5");
  chk_fixed_sel_span: assert property ((r.st == ems_pkg::ST_T1 && !r.is_int) ##1 r.st == ems_pkg::ST_T2
      |-> !fixed_select_strobe_n)
    else $error("fixed strobe not low at T2 start");
  chk_dur_zero_high: assert property (r.strc[4:0] == 5'h00 |-> duration_strobe_n)
    else $error("duration strobe low with zero setting");
  chk_dur_bound: assert property (!duration_strobe_n |-> r.scnt < {1'b0, r.strc[4:0]} && r.st != ems_pkg::ST_PAD)
    else $error("duration strobe low too long");
  chk_delay_zero_t6: assert property ((r.strc[9:5] == 5'h00 && r.st == ems_pkg::ST_T5 && !r.is_int)
      ##1 r.st == ems_pkg::ST_T6 |-> delayed_strobe_a_n)
    else $error("zero-delay strobe not high in T6");
  chk_write_strobe_win: assert property (byte_write_strobes_n != 4'hf |-> r.is_wr && !r.is_int &&
      (r.st inside {ems_pkg::ST_T4, ems_pkg::ST_WAIT, ems_pkg::ST_T5} ||
      (r.st == ems_pkg::ST_T3 && r.strc[20])))
    else $error("write strobe outside its window");
  chk_cycle_rising: assert property (seq_enter_t1 |-> processor_clock_output)
    else $error("cycle not started on rising edge");
  chk_t5_align_edge: assert property (seq_wait_to_t5 |-> processor_clock_output)
    else $error("T5 after wait not on rising edge");
  chk_t1_length: assert property (seq_enter_t1 |-> ##[1:4] r.st == ems_pkg::ST_T2)
    else $error("T1 longer than four half periods");
  chk_internal_quiet: assert property (r.is_int && r.st != ems_pkg::ST_IDLE |->
      byte_write_strobes_n == 4'hf && r.st != ems_pkg::ST_WAIT)
    else $error("internal access drove strobes or waited");

endmodule

// ### testbench/ems_mem_model.sv
// Purpose: Behavioural memory partner for the external cycle sequencer.
// Assumes: Strobes and the resolved data pins are seen at ref_clk edges.
// Notes: Sixteen words indexed by pin bits 5:2; drives the word while read strobe is low, else the inverse of the last word.
`timescale 1ns/1ps
module ems_mem_model (
  input wire logic ref_clk,
  input wire logic fixed_select_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [3:0] byte_write_strobes_n,
  input wire logic [31:0] data_pin,
  input wire logic [7:0] wait_len,
  input wire logic force_wait,
  output logic [31:0] mem_drv,
  output logic wait_request
);
  logic [31:0] mem [16]; // Storage words
  logic [3:0] idx = 4'h0; // Latched word index
  logic prev_s0 = 1'b1; // Fixed strobe one cycle back
  logic [3:0] prev_wr = 4'hf; // Byte strobes one cycle back
  logic [31:0] last = 32'h0000_0000; // Last word driven
  logic [7:0] wcnt = 8'h00; // Wait cycles still to hold

  // Known start pattern, one distinct word per index
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'h1234_5670 ^ 32'(i);
    end
  end

  // Word while read strobe low, inverse of last word once released
  assign mem_drv = !read_strobe_n ? mem[idx] : ~last;
  // Wait held for the commanded count from T2 start, or forced
  assign wait_request = force_wait | (wcnt != 8'h00);

  // Address latch, wait count and byte capture
  always @(posedge ref_clk) begin
    prev_s0 <= fixed_select_strobe_n;
    prev_wr <= byte_write_strobes_n;
    if (!read_strobe_n) begin
      last <= mem[idx];
    end
    // Address is still on the bus in the first cycle of T2
    if (prev_s0 && !fixed_select_strobe_n) begin
      idx <= data_pin[5:2];
      wcnt <= wait_len;
    end else if (wcnt != 8'h00) begin
      wcnt <= wcnt - 8'h01;
    end
    // Byte taken on the rising edge of its own strobe
    for (int b = 0; b < 4; b++) begin
      if (!prev_wr[b] && byte_write_strobes_n[b]) begin
        mem[idx][8*b +: 8] <= data_pin[8*b +: 8];
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the external cycle sequencer.
// Assumes: Registers reached over Avalon-MM; memory partner on the pins.
// Notes: Strobe low-cycle counts are taken per memory cycle and compared.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst, avs_read, avs_write, force_wait, avs_waitrequest, wait_req, pco;
  logic rd_n, s0_n, s1_n, sa_n, sb_n, sc_n, wf_out, wf_oe_n, rf_out, rf_oe_n;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, pin, mdrv, st;
  logic [3:0] avs_byteenable, wr_n, bus_oe_n;
  logic [29:0] bus_out, oen30;
  logic [7:0] wait_len;
  logic [9:0] lo;
  int error_cnt = 0, checked = 0, oe_bad = 0;
  int cnt [10] = '{default: 0}; // Low-cycle counters per watched signal
  int base [10], dl [10];
  int dur_tab [3] = '{0, 3, 31}; // Duration settings
  int dur_exp [3] = '{0, 3, 5}; // Low cycles, cut at T6 end

  // Pin levels resolved from the sequencer's enables, memory drives the rest
  assign oen30 = {{8{bus_oe_n[3]}}, {8{bus_oe_n[2]}}, {8{bus_oe_n[1]}}, {6{bus_oe_n[0]}}};
  assign pin[31:2] = (bus_out & ~oen30) | (mdrv[31:2] & oen30);
  assign pin[1] = rf_oe_n ? mdrv[1] : rf_out;
  assign pin[0] = wf_oe_n ? mdrv[0] : wf_out;
  // Bit 8: clock output high under fixed strobe; bit 9: lane 0 driven
  assign lo = {~bus_oe_n[0], ~s0_n & pco, ~wf_oe_n & ~wf_out, ~&wr_n, ~sc_n, ~sb_n, ~sa_n, ~s1_n, ~s0_n, ~rd_n};

  ems_seq dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .processor_clock_output(pco),
    .read_strobe_n(rd_n), .fixed_select_strobe_n(s0_n), .duration_strobe_n(s1_n),
    .delayed_strobe_a_n(sa_n), .delayed_strobe_b_n(sb_n), .delayed_strobe_c_n(sc_n),
    .byte_write_strobes_n(wr_n), .write_flag_data_bit0_out(wf_out), .write_flag_data_bit0_in(pin[0]),
    .write_flag_data_bit0_oe_n(wf_oe_n), .refresh_flag_data_bit1_out(rf_out),
    .refresh_flag_data_bit1_in(pin[1]), .refresh_flag_data_bit1_oe_n(rf_oe_n),
    .shared_addr_data_bus_out(bus_out), .shared_addr_data_bus_in(pin[31:2]),
    .shared_addr_data_bus_oe_n(bus_oe_n), .wait_request(wait_req));

  ems_mem_model mem_u (.ref_clk(ref_clk), .fixed_select_strobe_n(s0_n), .read_strobe_n(rd_n),
    .byte_write_strobes_n(wr_n), .data_pin(pin), .wait_len(wait_len), .force_wait(force_wait),
    .mem_drv(mdrv), .wait_request(wait_req));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Low-cycle counting and lane enable watch during byte strobes
  always @(posedge ref_clk) begin
    if (!rst) begin
      for (int i = 0; i < 10; i++) begin
        cnt[i] <= cnt[i] + int'(lo[i]);
      end
      if (wr_n != 4'hf && bus_oe_n !== wr_n) begin
        oe_bad <= oe_bad + 1;
      end
    end
  end

  task automatic final_report;
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t value got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 1000) begin
      error_cnt++;
      $display("ERROR %0t bus transfer timed out", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_cmp(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    cmp_val(q, exp);
  endtask

  // Start a memory cycle, poll busy, then take per-cycle low counts
  task automatic run(input logic [31:0] ctrl);
    int n;
    base = cnt;
    wr(ems_pkg::REG_CTRL, ctrl);
    n = 0;
    do begin
      bus(1'b0, ems_pkg::REG_STATUS, 32'h0000_0000, st);
      n++;
    end while (st[ems_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      $display("ERROR %0t memory cycle never finished", $time);
      final_report();
    end
    for (int i = 0; i < 10; i++) begin
      dl[i] = cnt[i] - base[i];
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    wait_len = 8'h00;
    force_wait = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_cmp(ems_pkg::REG_TIMING, 32'(ems_pkg::TIM_RST));
    rd_cmp(ems_pkg::REG_STROBE, 32'h0000_0000);
    rd_cmp(5'h1c, 32'h0000_0000);
    // Slow default timing, read with inserted waits
    wr(ems_pkg::REG_STROBE, 32'h0000_0003);
    wr(ems_pkg::REG_ADDR, 32'h0000_000c);
    wait_len <= 8'h0c;
    run(32'h0000_00f1);
    wait_len <= 8'h00;
    cmp_val({31'h0000_0000, st[ems_pkg::STAT_WAITED_BIT]}, 32'h0000_0001);
    cmp_cnt(int'(dl[0] > 8), 1);
    cmp_cnt(dl[0] % 2, 0);
    cmp_cnt(dl[1], dl[0] + 8);
    cmp_cnt(dl[2], 3);
    rd_cmp(ems_pkg::REG_RDATA, 32'h1234_5673);
    // Unit state lengths, duration and delay table
    wr(ems_pkg::REG_TIMING, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      wr(ems_pkg::REG_STROBE, 32'h0002_8800 | 32'(dur_tab[k]));
      run(32'h0000_00f1);
      cmp_cnt(dl[0], 2);
      cmp_cnt(dl[1], 4);
      cmp_cnt(dl[2], dur_exp[k]);
      cmp_cnt(dl[3], 5);
      cmp_cnt(dl[4], 2);
      cmp_cnt(dl[5], 0);
      cmp_cnt(dl[7], 0);
      cmp_cnt(dl[8], 2);
      cmp_cnt(dl[9], 2);
      rd_cmp(ems_pkg::REG_RDATA, 32'h1234_5673);
    end
    // Partial writes in late then early mode, two-half-period T6 forces padding
    wr(ems_pkg::REG_TIMING, 32'h0000_0400);
    wr(ems_pkg::REG_ADDR, 32'h0000_0014);
    wr(ems_pkg::REG_WDATA, 32'hdead_beef);
    for (int e = 0; e < 2; e++) begin
      wr(ems_pkg::REG_STROBE, 32'(e) << ems_pkg::STR_EARLY_BIT);
      run(32'h0000_0053);
      cmp_cnt(dl[6], 2 + e);
      cmp_cnt(dl[7], 2);
      cmp_cnt(dl[9], 8);
      cmp_val(mem_u.mem[5], 32'h12ad_56ef);
    end
    cmp_cnt(oe_bad, 0);
    // Internal access with wait held high
    force_wait <= 1'b1;
    run(32'h0000_00f7);
    force_wait <= 1'b0;
    cmp_cnt(dl[6], 0);
    cmp_cnt(dl[1], 0);
    cmp_val({31'h0000_0000, st[ems_pkg::STAT_WAITED_BIT]}, 32'h0000_0000);
    cmp_val(mem_u.mem[5], 32'h12ad_56ef);
    final_report();
  end
endmodule
